// File: design/isc_cfg.svh
// Constants for the internal clock generator settling controller
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ISC_SYS_HZ 40000000
`define ISC_BASE_REF_HZ 307200
`define ISC_BASE_DIV (`ISC_SYS_HZ / `ISC_BASE_REF_HZ)
`define ISC_STEP_BASE_PERIODS 2'd3
// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define ISC_MULT_RESET 7'h15
`define ISC_TRIM_RESET 8'h80
`define ISC_TRIM_FIXED 10'h180
`define ISC_TRIM_SHIFT 9
`define ISC_STAGE_RESET 8'h80
`define ISC_DIV_RESET 4'h0
`define ISC_DIV_MAX 4'h9
`define ISC_STEP_COARSE 8'h20
`define ISC_STEP_MED 8'h08
`define ISC_STEP_FINE 8'h01
`define ISC_DCO_TOP 10'h2ff
`define ISC_XTAL_STAB 13'h1000
`define ISC_EXT_STAB 13'h0010
`endif

// File: design/isc_clock_gen.sv
// Internal clock generator with loop filter settling and stop handling
`timescale 1ns/1ps
`include "isc_cfg.svh"
module isc_clock_gen
    import isc_pkg::*;
#(
    parameter int MULT_W = 7,
    parameter int CNT_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [MULT_W-1:0] mult_factor_in,   // New multiply factor
    input wire logic mult_wr,                       // Write pulse for factor
    input wire logic [7:0] trim_in,                 // New capacitor adjust value
    input wire logic trim_wr,                       // Write pulse for trim
    input wire logic internal_gen_enable,           // Internal generator on
    input wire logic external_gen_enable,           // External path on
    input wire logic ext_clk_pin,                   // External clock, asynchronous
    input wire logic crystal_mode_option,           // Long external stabilization
    input wire logic keep_running_in_stop,          // Keep generating in stop
    input wire logic stop_mode,                     // CPU executed stop
    input wire logic wait_mode,                     // CPU executed wait
    input wire logic watch_set,                     // Request watcher on
    input wire logic watch_clr,                     // Request watcher off
    input wire logic watch_irq_set,                 // Request interrupt enable
    input wire logic watch_irq_clr,                 // Clear interrupt enable
    input wire logic watch_fault,                   // Inactivity seen by watcher
    input wire logic watch_flag_clr,                // Software clears flag
    output logic internal_clock,
    output logic reference_clock_out,
    output logic bus_source_clock_out,
    output logic timebase_clock_out,
    output logic internal_stable_flag,
    output logic external_stable_flag,
    output logic clock_watch_enable,
    output logic watch_irq_enable,
    output logic watch_flag,
    output logic watch_irq,
    output logic wake_req,
    output logic [MULT_W-1:0] mult_factor,
    output logic [7:0] trim_value,
    output logic [3:0] divider_ctrl_word,
    output logic [7:0] stage_ctrl_word
);
    // ----------------------------------------------------------------
    // Stop and restart decoding
    // ----------------------------------------------------------------
    logic stop_reg;            // Halting stop seen last cycle
    logic gen_on_reg;          // Generator running last cycle
    wire halted = stop_mode & ~keep_running_in_stop;
    wire running = internal_gen_enable & ~halted;
    wire stop_entry = halted & ~stop_reg;
    // Settling restarts on any write or when the generator comes back
    wire restart = mult_wr | trim_wr | (running & ~gen_on_reg);

    // Stored values; stop leaves mult_factor and trim_value alone
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mult_factor <= MULT_W'(`ISC_MULT_RESET);
            trim_value <= `ISC_TRIM_RESET;
            stop_reg <= 1'b0;
            gen_on_reg <= 1'b0;
        end else begin
            if (mult_wr) mult_factor <= mult_factor_in;
            if (trim_wr) trim_value <= trim_in;
            stop_reg <= halted;
            gen_on_reg <= running;
        end
    end

    // ----------------------------------------------------------------
    // Base reference divider
    // ----------------------------------------------------------------
    // Bigger trim means a larger capacitor, a longer base period
    logic [9:0] base_cnt_reg;
    wire [9:0] trim_units = `ISC_TRIM_FIXED + {2'b00, trim_value};
    wire [18:0] base_prod = 19'(`ISC_BASE_DIV) * {9'h000, trim_units};
    wire [9:0] base_limit = base_prod[`ISC_TRIM_SHIFT +: 10];
    wire base_tick = running & (base_cnt_reg == 10'h000);

    // Down counter, one tick per base period
    always_ff @(posedge sys_clk) begin
        if (!rst_n || restart || !running) begin
            base_cnt_reg <= base_limit;
        end else if (base_tick) begin
            base_cnt_reg <= base_limit;
        end else begin
            base_cnt_reg <= base_cnt_reg - 10'h001;
        end
    end

    // ----------------------------------------------------------------
    // Digitally controlled oscillator model
    // ----------------------------------------------------------------
    // Phase accumulator; a larger stage word slows it, each divider step halves it
    logic [9:0] acc_reg;
    wire [9:0] dco_inc = `ISC_DCO_TOP - {2'b00, stage_ctrl_word};
    wire [10:0] acc_sum = {1'b0, acc_reg} + ({1'b0, dco_inc} >> divider_ctrl_word);
    wire ick_tick = running & acc_sum[10];

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !running) begin
            acc_reg <= 10'h000;
        end else begin
            acc_reg <= acc_sum[9:0];
        end
    end

    // ----------------------------------------------------------------
    // Loop filter measurement
    // ----------------------------------------------------------------
    logic [1:0] step_cnt_reg;       // Base periods inside this step
    logic [CNT_W-1:0] ick_cnt_reg;  // Internal ticks inside this step
    wire step_end = base_tick & (step_cnt_reg == `ISC_STEP_BASE_PERIODS);
    // Ideal count over four base periods is four times the factor
    wire [CNT_W-1:0] target = CNT_W'({mult_factor, 2'b00});
    wire [CNT_W-1:0] meas = ick_cnt_reg + CNT_W'(ick_tick);
    wire too_fast = meas > target;
    wire [CNT_W-1:0] err_mag = too_fast ? meas - target : target - meas;
    wire [CNT_W+4:0] err20 = (CNT_W+5)'(err_mag) * (CNT_W+5)'(20);
    wire [CNT_W+4:0] tgt3 = (CNT_W+5)'(target) * (CNT_W+5)'(3);
    wire [CNT_W+4:0] tgt1 = (CNT_W+5)'(target);
    wire over15 = err20 > tgt3;
    wire over5 = err20 > tgt1;

    // Correction band picked afresh from every measurement
    isc_band_t band;
    assign band = over15 ? ISC_BAND_COARSE :
                  over5 ? ISC_BAND_MED :
                  (err_mag != '0) ? ISC_BAND_FINE : ISC_BAND_NONE;

    logic [7:0] step_size;
    always_comb begin
        unique case (band)
            ISC_BAND_COARSE: step_size = `ISC_STEP_COARSE;
            ISC_BAND_MED: step_size = `ISC_STEP_MED;
            ISC_BAND_FINE: step_size = `ISC_STEP_FINE;
            ISC_BAND_NONE: step_size = 8'h00;
        endcase
    end

    // Counters restart with the step so each measurement is clean
    always_ff @(posedge sys_clk) begin
        if (!rst_n || restart || !running) begin
            step_cnt_reg <= 2'd0;
            ick_cnt_reg <= '0;
        end else if (step_end) begin
            step_cnt_reg <= 2'd0;
            ick_cnt_reg <= '0;
        end else begin
            if (base_tick) step_cnt_reg <= step_cnt_reg + 2'd1;
            if (ick_tick) ick_cnt_reg <= meas;
        end
    end

    // ----------------------------------------------------------------
    // Stage and divider words
    // ----------------------------------------------------------------
    // Only a carry or borrow out of the stage word moves the divider
    wire [8:0] stg_up = {1'b0, stage_ctrl_word} + {1'b0, step_size};
    wire [8:0] stg_dn = {1'b0, stage_ctrl_word} - {1'b0, step_size};
    wire div_at_max = divider_ctrl_word >= `ISC_DIV_MAX;
    wire div_at_min = divider_ctrl_word == 4'h0;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage_ctrl_word <= `ISC_STAGE_RESET;
            divider_ctrl_word <= `ISC_DIV_RESET;
        end else if (step_end && !restart) begin
            if (too_fast) begin
                // Too many ticks: lengthen the period
                if (!stg_up[8]) begin
                    stage_ctrl_word <= stg_up[7:0];
                end else if (!div_at_max) begin
                    stage_ctrl_word <= stg_up[7:0];
                    divider_ctrl_word <= divider_ctrl_word + 4'h1;
                end else begin
                    stage_ctrl_word <= 8'hff;
                end
            end else begin
                // Too few ticks: shorten the period
                if (!stg_dn[8]) begin
                    stage_ctrl_word <= stg_dn[7:0];
                end else if (!div_at_min) begin
                    stage_ctrl_word <= stg_dn[7:0];
                    divider_ctrl_word <= divider_ctrl_word - 4'h1;
                end else begin
                    stage_ctrl_word <= 8'h00;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Stable flags and external stabilization
    // ----------------------------------------------------------------
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic [12:0] ext_cnt_reg;
    wire ext_edge = ext_s2_reg & ~ext_s3_reg;
    wire [12:0] ext_limit = crystal_mode_option ? `ISC_XTAL_STAB : `ISC_EXT_STAB;

    // Internal stable once an in-band step measures at most five percent
    always_ff @(posedge sys_clk) begin
        if (!rst_n || restart || !running || stop_entry) begin
            internal_stable_flag <= 1'b0;
        end else if (step_end && !over5) begin
            internal_stable_flag <= 1'b1;
        end
    end

    // Pin passes two flops before the edge detector looks at it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_pin;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // Stabilization divider reruns after stop clears the flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !external_gen_enable || stop_entry || halted) begin
            ext_cnt_reg <= 13'h0000;
            external_stable_flag <= 1'b0;
        end else if (!external_stable_flag && ext_edge) begin
            if (ext_cnt_reg + 13'h0001 >= ext_limit) begin
                external_stable_flag <= 1'b1;
            end
            ext_cnt_reg <= ext_cnt_reg + 13'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Activity watcher control
    // ----------------------------------------------------------------
    // Turning on needs both generators on and both stable
    wire watch_allowed = internal_gen_enable & external_gen_enable &
                         internal_stable_flag & external_stable_flag;
    wire watch_off = watch_clr | stop_entry;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || watch_off) begin
            clock_watch_enable <= 1'b0;
            watch_irq_enable <= 1'b0;
            watch_flag <= 1'b0;
        end else begin
            if (watch_set && watch_allowed) clock_watch_enable <= 1'b1;
            if (watch_irq_clr) begin
                watch_irq_enable <= 1'b0;
            end else if (watch_irq_set && clock_watch_enable) begin
                watch_irq_enable <= 1'b1;
            end
            // Fault beats a same-cycle software clear
            if (watch_fault && clock_watch_enable) begin
                watch_flag <= 1'b1;
            end else if (watch_flag_clr) begin
                watch_flag <= 1'b0;
            end
        end
    end

    assign watch_irq = watch_flag & watch_irq_enable;
    // Wakes from wait, never from stop
    assign wake_req = watch_irq & wait_mode & ~stop_mode;

    // ----------------------------------------------------------------
    // Clock outputs
    // ----------------------------------------------------------------
    // Outputs are toggled flops, forced low whenever halted in stop
    logic bus_div_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !running) begin
            internal_clock <= 1'b0;
            bus_div_reg <= 1'b0;
        end else if (ick_tick) begin
            internal_clock <= ~internal_clock;
            if (internal_clock) bus_div_reg <= ~bus_div_reg;
        end
    end

    assign reference_clock_out = internal_clock;
    assign timebase_clock_out = internal_clock;
    assign bus_source_clock_out = bus_div_reg;
endmodule : isc_clock_gen

// File: design/isc_pkg.sv
// Types for the internal clock generator settling controller
package isc_pkg;
    // Loop filter correction size
    typedef enum logic [1:0] {
        ISC_BAND_NONE,
        ISC_BAND_FINE,
        ISC_BAND_MED,
        ISC_BAND_COARSE
    } isc_band_t;
endpackage : isc_pkg

// File: sim/isc_clock_gen_assertions.sv
// Concurrent checks on the ports of the internal clock generator
`timescale 1ns/1ps
module isc_clock_gen_assertions #(
    parameter int MULT_W = 7
) (
    input logic sys_clk,
    input logic rst_n,
    input logic mult_wr,
    input logic [7:0] trim_in,
    input logic trim_wr,
    input logic keep_running_in_stop,
    input logic stop_mode,
    input logic wait_mode,
    input logic watch_set,
    input logic reference_clock_out,
    input logic bus_source_clock_out,
    input logic timebase_clock_out,
    input logic internal_stable_flag,
    input logic external_stable_flag,
    input logic clock_watch_enable,
    input logic watch_irq_enable,
    input logic watch_flag,
    input logic watch_irq,
    input logic wake_req,
    input logic [MULT_W-1:0] mult_factor,
    input logic [7:0] trim_value,
    input logic [3:0] divider_ctrl_word,
    input logic [7:0] stage_ctrl_word
);
    // ----------------------------------------------------------------
    // One clock domain, reset masks everything
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Halting stop: no keep-running option
    sequence s_halt;
        stop_mode && !keep_running_in_stop;
    endsequence
    property p_refuse; watch_set && !internal_stable_flag && !clock_watch_enable
        |=> !clock_watch_enable; endproperty
    property p_mult; mult_wr |=> !internal_stable_flag; endproperty
    property p_trim; trim_wr |=> trim_value == $past(trim_in) && !internal_stable_flag; endproperty
    property p_clk_low; s_halt |=> !reference_clock_out && !bus_source_clock_out
        && !timebase_clock_out; endproperty
    property p_flags; s_halt |=> !internal_stable_flag && !external_stable_flag; endproperty
    property p_watch; s_halt |=> !clock_watch_enable && !watch_irq_enable && !watch_flag;
    endproperty
    // Two halted cycles so a factor or trim write on entry cannot trip it
    property p_keep; s_halt ##1 (stop_mode && !keep_running_in_stop && !mult_wr && !trim_wr)
        |=> $stable(mult_factor)
        && $stable(trim_value) && $stable(divider_ctrl_word) && $stable(stage_ctrl_word);
    endproperty
    property p_wake; watch_irq && wait_mode && !stop_mode |-> wake_req; endproperty
    property p_nowake; stop_mode |-> !wake_req; endproperty
    // A correction spans four base periods, far more than eight cycles
    property p_gap; $changed(stage_ctrl_word) |=> $stable(stage_ctrl_word) [*8]; endproperty
    a_refuse: assert property (p_refuse) else $error("watcher enabled while unstable");
    a_mult: assert property (p_mult) else $error("factor write kept stable flag");
    a_trim: assert property (p_trim) else $error("trim write wrong");
    a_clk_low: assert property (p_clk_low) else $error("clock out high in stop");
    a_flags: assert property (p_flags) else $error("stable flag in stop");
    a_watch: assert property (p_watch) else $error("watcher bits in stop");
    a_keep: assert property (p_keep) else $error("words changed in stop");
    a_wake: assert property (p_wake) else $error("no wake from wait");
    a_nowake: assert property (p_nowake) else $error("wake during stop");
    a_gap: assert property (p_gap) else $error("correction steps too close");
endmodule : isc_clock_gen_assertions

// File: sim/isc_clock_gen_tb_top.sv
// Self-checking testbench for the internal clock generator
`timescale 1ns/1ps
module isc_clock_gen_tb_top;
    // ----------------------------------------------------------------
    // Stimulus, observed outputs and counters
    // ----------------------------------------------------------------
    logic sys_clk, rst_n, mult_wr, trim_wr, internal_gen_enable, external_gen_enable;
    logic keep_running_in_stop, stop_mode, wait_mode, watch_set, watch_clr, watch_irq_set;
    logic watch_fault, ext_clk_pin, internal_clock, reference_clock_out, bus_source_clock_out;
    logic timebase_clock_out, internal_stable_flag, external_stable_flag, clock_watch_enable;
    logic watch_irq_enable, watch_flag, watch_irq, wake_req, crystal_mode_option;
    logic [6:0] mult_factor_in, mult_factor;
    logic [7:0] trim_in, trim_value, stage_ctrl_word;
    logic [3:0] divider_ctrl_word;
    int errors = 0, cmp_count = 0, ext_edges = 0, toggles = 0, k, t0;
    isc_clock_gen u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .mult_factor_in(mult_factor_in),
        .mult_wr(mult_wr), .trim_in(trim_in), .trim_wr(trim_wr),
        .internal_gen_enable(internal_gen_enable), .external_gen_enable(external_gen_enable),
        .ext_clk_pin(ext_clk_pin), .crystal_mode_option(crystal_mode_option),
        .keep_running_in_stop(keep_running_in_stop), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .watch_set(watch_set), .watch_clr(watch_clr),
        .watch_irq_set(watch_irq_set), .watch_irq_clr(1'b0), .watch_fault(watch_fault),
        .watch_flag_clr(1'b0), .internal_clock(internal_clock),
        .reference_clock_out(reference_clock_out), .bus_source_clock_out(bus_source_clock_out),
        .timebase_clock_out(timebase_clock_out), .internal_stable_flag(internal_stable_flag),
        .external_stable_flag(external_stable_flag), .clock_watch_enable(clock_watch_enable),
        .watch_irq_enable(watch_irq_enable), .watch_flag(watch_flag), .watch_irq(watch_irq),
        .wake_req(wake_req), .mult_factor(mult_factor), .trim_value(trim_value),
        .divider_ctrl_word(divider_ctrl_word), .stage_ctrl_word(stage_ctrl_word));
    isc_ext_osc u_osc (.run(external_gen_enable), .osc_out(ext_clk_pin));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Edge and toggle counts for rate checks
    always @(posedge ext_clk_pin) ext_edges++;
    always @(internal_clock) toggles++;
    task report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Ends the run when a bounded wait ran out
    task bound(input int lim);
        if (k >= lim) begin
            errors++;
            $display("FAIL wait expected %0d seen %0d", lim - 1, k);
            report_and_stop();
        end
    endtask : bound
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, mult_wr, trim_wr, external_gen_enable, keep_running_in_stop} = 5'h00;
        {stop_mode, wait_mode, watch_set, watch_clr, watch_irq_set, watch_fault} = 6'h00;
        internal_gen_enable = 1'b1;
        crystal_mode_option = 1'b0;
        mult_factor_in = 7'h0a;
        trim_in = 8'h7c;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk) watch_set <= 1'b1;
        @(posedge sys_clk) watch_set <= 1'b0;
        @(negedge sys_clk);
        chk("mult_factor", 8'h15, {1'b0, mult_factor});
        chk("trim_value", 8'h80, trim_value);
        chk("stage_word", 8'h80, stage_ctrl_word);
        chk("watch_early", 8'h00, {7'h0, clock_watch_enable});
        $display("test reset done");
        @(posedge sys_clk) external_gen_enable <= 1'b1;
        for (k = 0; k < 400 && external_stable_flag !== 1'b1; k++) @(negedge sys_clk);
        bound(400);
        chk("ext_edges", 8'h01, {7'h0, ext_edges >= 16 && ext_edges <= 17});
        for (k = 0; k < 60000 && internal_stable_flag !== 1'b1; k++) @(negedge sys_clk);
        bound(60000);
        chk("divider_word", 8'h02, {4'h0, divider_ctrl_word});
        // Let the fine band pull away from the five percent edge first
        repeat (5240) @(posedge sys_clk);
        t0 = toggles;
        repeat (5240) @(posedge sys_clk);
        chk("rate_ok", 8'h01, {7'h0, toggles - t0 >= 798 && toggles - t0 <= 882});
        $display("test settling done");
        @(posedge sys_clk) watch_set <= 1'b1;
        @(posedge sys_clk) {watch_set, watch_irq_set} <= 2'b01;
        @(posedge sys_clk) {watch_irq_set, watch_fault, wait_mode} <= 3'b011;
        @(posedge sys_clk) watch_fault <= 1'b0;
        @(negedge sys_clk);
        chk("watch_on", 8'h01, {7'h0, clock_watch_enable});
        chk("wake_wait", 8'h01, {7'h0, wake_req});
        @(posedge sys_clk) {keep_running_in_stop, stop_mode} <= 2'b11;
        repeat (4) @(negedge sys_clk);
        chk("wake_stop", 8'h00, {7'h0, wake_req});
        chk("run_in_stop", 8'h03, {6'h0, internal_stable_flag, clock_watch_enable});
        @(posedge sys_clk) keep_running_in_stop <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("clocks_low", 8'h00, {5'h0, reference_clock_out, bus_source_clock_out,
            timebase_clock_out});
        chk("flags_clr", 8'h00, {6'h0, internal_stable_flag, external_stable_flag});
        chk("watch_clr", 8'h00, {5'h0, clock_watch_enable, watch_irq_enable, watch_flag});
        chk("kept", 8'h95, {divider_ctrl_word[1:0], 1'b0, mult_factor[4:0]});
        $display("test low power done");
        @(posedge sys_clk) {stop_mode, wait_mode} <= 2'b00;
        for (k = 0; k < 5000 && internal_stable_flag !== 1'b1; k++) @(negedge sys_clk);
        bound(5000);
        @(posedge sys_clk) watch_clr <= 1'b1;
        @(posedge sys_clk) {watch_clr, mult_wr} <= 2'b01;
        @(posedge sys_clk) {mult_wr, trim_wr, watch_set} <= 3'b011;
        @(posedge sys_clk) {trim_wr, watch_set} <= 2'b00;
        @(negedge sys_clk);
        chk("mult_new", 8'h0a, {1'b0, mult_factor});
        chk("trim_new", 8'h7c, trim_value);
        chk("restart", 8'h00, {6'h0, internal_stable_flag, clock_watch_enable});
        $display("test restart done");
        // Crystal count; path held off long enough for the pin and synchroniser to rest
        @(posedge sys_clk) {external_gen_enable, crystal_mode_option} <= 2'b01;
        repeat (6) @(posedge sys_clk);
        external_gen_enable <= 1'b1;
        ext_edges = 0;
        for (k = 0; k < 13000 && external_stable_flag !== 1'b1; k++) @(negedge sys_clk);
        bound(13000);
        chk("xtal_edges", 8'h01, {7'h0, ext_edges >= 4096 && ext_edges <= 4097});
        $display("test crystal done");
        report_and_stop();
    end
endmodule : isc_clock_gen_tb_top
bind isc_clock_gen isc_clock_gen_assertions #(.MULT_W(MULT_W)) u_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .mult_wr(mult_wr), .trim_in(trim_in), .trim_wr(trim_wr),
    .keep_running_in_stop(keep_running_in_stop), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .watch_set(watch_set), .reference_clock_out(reference_clock_out),
    .bus_source_clock_out(bus_source_clock_out), .timebase_clock_out(timebase_clock_out),
    .internal_stable_flag(internal_stable_flag), .external_stable_flag(external_stable_flag),
    .clock_watch_enable(clock_watch_enable), .watch_irq_enable(watch_irq_enable),
    .watch_flag(watch_flag), .watch_irq(watch_irq), .wake_req(wake_req),
    .mult_factor(mult_factor), .trim_value(trim_value),
    .divider_ctrl_word(divider_ctrl_word), .stage_ctrl_word(stage_ctrl_word));

// File: sim/isc_ext_osc.sv
// External clock source on the far side of the generator
`timescale 1ns/1ps
module isc_ext_osc (
    input wire logic run,
    output logic osc_out
);
    // ----------------------------------------------------------------
    // Free period unrelated to the system clock; still and low when off
    // ----------------------------------------------------------------
    initial osc_out = 1'b0;
    always begin
        #37;
        osc_out = run ? ~osc_out : 1'b0;
    end
endmodule : isc_ext_osc
